// ---- verilog/tws_params.svh ----
`ifndef TWS_PARAMS_SVH
`define TWS_PARAMS_SVH
`define TWS_OFS_OAR 12'h000
`define TWS_OFS_CTRL 12'h004
`define TWS_OFS_STAT 12'h008
`define TWS_OFS_DATA 12'h00C
`define TWS_OFS_PWR 12'h010
`define TWS_CTRL_FLAG 7
`define TWS_CTRL_EA 6
`define TWS_CTRL_STA 5
`define TWS_CTRL_STO 4
`define TWS_CTRL_WC 3
`define TWS_CTRL_EN 2
`define TWS_CTRL_IE 0
`define TWS_OAR_RST 8'h00
`define TWS_CODE_IDLE 8'hF8
`define TWS_CODE_START 8'h08
`define TWS_CODE_OWN_W 8'h60
`define TWS_CODE_ARB_OWN_W 8'h68
`define TWS_CODE_GC_HIT 8'h70
`define TWS_CODE_ARB_GC_HIT 8'h78
`define TWS_CODE_RX_ACK 8'h80
`define TWS_CODE_RX_NACK 8'h88
`define TWS_CODE_GC_ACK 8'h90
`define TWS_CODE_GC_NACK 8'h98
`define TWS_CODE_STOP 8'hA0
`define TWS_CODE_OWN_R 8'hA8
`define TWS_CODE_ARB_OWN_R 8'hB0
`define TWS_CODE_TX_ACK 8'hB8
`define TWS_CODE_TX_NACK 8'hC0
`define TWS_CODE_TX_LAST_ACK 8'hC8
`define TWS_GC_ADDR 8'h00
`define TWS_CLK_NS 50
`define TWS_START_HOLD_NS 4000
`define TWS_START_HOLD_CYC ((`TWS_START_HOLD_NS + `TWS_CLK_NS - 1) / `TWS_CLK_NS)
`endif

// ---- verilog/tws_pkg.sv ----
package tws_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_RX, ST_TX, ST_ACK_OUT, ST_ACK_IN, ST_WAIT, ST_GEN_START
  } tws_state_t;
  typedef enum logic [1:0] {ACT_NONE, ACT_RX, ACT_TX, ACT_NAS} tws_act_t;
  typedef enum logic [2:0] {REG_OAR, REG_CTRL, REG_STAT, REG_DATA, REG_PWR, REG_NONE} tws_reg_t;
  typedef struct packed {
    logic scl_out;
    logic scl_oe;
    logic sda_out;
    logic sda_oe;
  } tws_drive_t;
  typedef struct packed {
    tws_state_t st;
    tws_act_t act;
    logic [7:0] sh;
    logic [3:0] cnt;
    logic ack_drv;
    logic last;
    logic gc;
    logic adr;
    logic busy;
    logic spend;
    logic arb;
    logic flag;
    logic [7:0] code;
    logic [7:0] pcode;
    logic [1:0] presc;
    logic ea;
    logic sta;
    logic sto;
    logic wc;
    logic en;
    logic ie;
    logic [7:0] oar;
    logic [7:0] dr;
    logic sleep;
    logic wake;
    logic [6:0] tmr;
    logic [31:0] rdata;
    logic sda_low;
    logic scl_low;
    logic scl_m;
    logic scl_s;
    logic scl_p;
    logic sda_m;
    logic sda_s;
    logic sda_p;
  } tws_core_t;
endpackage : tws_pkg

// ---- verilog/tws_engine.sv ----
`include "tws_params.svh"

module tws_engine (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic arb_lost,
  output tws_pkg::tws_drive_t line,
  output logic wake_req
);

  tws_pkg::tws_core_t s;
  tws_pkg::tws_core_t n;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic wr;
  logic clr_wr;
  logic own_hit;
  logic gc_hit;
  logic [7:0] abyte;

  // register decode, shared by read capture, write and error answer
  function automatic tws_pkg::tws_reg_t reg_sel(input logic [11:0] a);
    unique case (a)
      `TWS_OFS_OAR: reg_sel = tws_pkg::REG_OAR;
      `TWS_OFS_CTRL: reg_sel = tws_pkg::REG_CTRL;
      `TWS_OFS_STAT: reg_sel = tws_pkg::REG_STAT;
      `TWS_OFS_DATA: reg_sel = tws_pkg::REG_DATA;
      `TWS_OFS_PWR: reg_sel = tws_pkg::REG_PWR;
      default: reg_sel = tws_pkg::REG_NONE;
    endcase
  endfunction : reg_sel

  // bus conditions seen on the synchronised lines; stage one is never read here
  assign scl_rise = s.scl_s & ~s.scl_p;
  assign scl_fall = ~s.scl_s & s.scl_p;
  assign start_det = s.scl_s & s.scl_p & s.sda_p & ~s.sda_s;
  assign stop_det = s.scl_s & s.scl_p & ~s.sda_p & s.sda_s;
  assign wr = psel & penable & pwrite;
  assign clr_wr = wr && reg_sel(paddr) == tws_pkg::REG_CTRL && pwdata[`TWS_CTRL_FLAG] && s.flag;

  // address byte as it stands at the eighth rising edge
  assign abyte = {s.sh[6:0], s.sda_s};
  assign own_hit = abyte[7:1] == s.oar[7:1] && s.ea;
  assign gc_hit = abyte == `TWS_GC_ADDR && s.oar[0] && s.ea;

  // zero-wait slave; read data is captured in the setup cycle so it leaves a flop
  assign pready = 1'b1;
  assign pslverr = psel & penable & (reg_sel(paddr) == tws_pkg::REG_NONE);
  assign prdata = s.rdata;
  assign line = '{scl_out: 1'b0, scl_oe: s.scl_low, sda_out: 1'b0, sda_oe: s.sda_low};
  assign wake_req = s.wake;

  always_comb begin
    n = s;
    n.scl_m = scl_in;
    n.scl_s = s.scl_m;
    n.scl_p = s.scl_s;
    n.sda_m = sda_in;
    n.sda_s = s.sda_m;
    n.sda_p = s.sda_s;
    if (arb_lost) begin
      n.arb = 1'b1;
    end
    // read capture
    if (psel && !penable) begin
      unique case (reg_sel(paddr))
        tws_pkg::REG_OAR: n.rdata = 32'(s.oar);
        tws_pkg::REG_CTRL: n.rdata = 32'({s.flag, s.ea, s.sta, s.sto, s.wc, s.en, 1'b0, s.ie});
        tws_pkg::REG_STAT: n.rdata = 32'({s.code[7:3], 1'b0, s.presc});
        tws_pkg::REG_DATA: n.rdata = 32'(s.dr);
        tws_pkg::REG_PWR: n.rdata = 32'(s.sleep);
        tws_pkg::REG_NONE: n.rdata = 32'h0000_0000;
      endcase
    end
    // software writes; a data write while the flag is clear only flags a collision
    if (wr) begin
      unique case (reg_sel(paddr))
        tws_pkg::REG_OAR: n.oar = pwdata[7:0];
        tws_pkg::REG_CTRL: begin
          n.ea = pwdata[`TWS_CTRL_EA];
          n.sta = pwdata[`TWS_CTRL_STA];
          n.sto = pwdata[`TWS_CTRL_STO];
          n.en = pwdata[`TWS_CTRL_EN];
          n.ie = pwdata[`TWS_CTRL_IE];
        end
        tws_pkg::REG_STAT: n.presc = pwdata[1:0];
        tws_pkg::REG_DATA: begin
          if (s.flag) begin
            n.dr = pwdata[7:0];
          end else begin
            n.wc = 1'b1;
          end
        end
        tws_pkg::REG_PWR: n.sleep = pwdata[0];
        tws_pkg::REG_NONE: n.rdata = s.rdata;
      endcase
    end
    // flag clear releases SCL and runs the step chosen by bits written with it
    if (clr_wr) begin
      n.flag = 1'b0;
      n.wc = 1'b0;
      n.wake = 1'b0;
      n.code = `TWS_CODE_IDLE;
      n.act = tws_pkg::ACT_NONE;
      unique case (s.act)
        tws_pkg::ACT_RX: begin
          if (s.st == tws_pkg::ST_WAIT) begin
            n.st = tws_pkg::ST_RX;
            n.cnt = 4'h0;
            n.ack_drv = pwdata[`TWS_CTRL_EA];
          end
        end
        tws_pkg::ACT_TX: begin
          if (s.st == tws_pkg::ST_WAIT) begin
            n.st = tws_pkg::ST_TX;
            n.cnt = 4'h0;
            n.sh = s.dr;
            n.last = ~pwdata[`TWS_CTRL_EA];
            n.sda_low = ~s.dr[7];
          end
        end
        tws_pkg::ACT_NAS, tws_pkg::ACT_NONE: begin
          if (s.st == tws_pkg::ST_WAIT) begin
            n.st = tws_pkg::ST_IDLE;
            n.sda_low = 1'b0;
          end
          n.adr = 1'b0;
          n.gc = 1'b0;
          n.arb = 1'b0;
          n.sto = 1'b0;
          n.spend = pwdata[`TWS_CTRL_STA];
        end
      endcase
    end
    // bus engine comes last so a hardware flag set beats a clear in the same cycle
    if (!s.en) begin
      n.st = tws_pkg::ST_IDLE;
      n.adr = 1'b0;
      n.sda_low = 1'b0;
    end else if ((start_det || stop_det) && s.st != tws_pkg::ST_GEN_START) begin
      n.busy = start_det;
      n.sda_low = 1'b0;
      n.cnt = 4'h0;
      n.sh = 8'h00;
      n.st = start_det ? tws_pkg::ST_ADDR : tws_pkg::ST_IDLE;
      if (s.adr) begin
        n.flag = 1'b1;
        n.code = `TWS_CODE_STOP;
        n.act = tws_pkg::ACT_NAS;
        n.adr = 1'b0;
      end
    end else begin
      unique case (s.st)
        tws_pkg::ST_IDLE: begin
          if (s.spend && !s.busy) begin
            n.st = tws_pkg::ST_GEN_START;
            n.spend = 1'b0;
            n.busy = 1'b1;
            n.tmr = 7'h00;
            n.sda_low = 1'b1;
          end
        end
        tws_pkg::ST_ADDR, tws_pkg::ST_RX: begin
          if (scl_rise) begin
            n.sh = abyte;
            n.cnt = s.cnt + 4'h1;
            if (s.st == tws_pkg::ST_ADDR && s.cnt == 4'h7) begin
              // matching runs from sampled SCL, so it also works while the core sleeps
              if (own_hit || (gc_hit && !s.sda_s)) begin
                n.adr = 1'b1;
                n.gc = ~own_hit;
                n.ack_drv = 1'b1;
                if (own_hit && s.sda_s) begin
                  n.act = tws_pkg::ACT_TX;
                  n.pcode = s.arb ? `TWS_CODE_ARB_OWN_R : `TWS_CODE_OWN_R;
                end else begin
                  n.act = tws_pkg::ACT_RX;
                  if (own_hit) begin
                    n.pcode = s.arb ? `TWS_CODE_ARB_OWN_W : `TWS_CODE_OWN_W;
                  end else begin
                    n.pcode = s.arb ? `TWS_CODE_ARB_GC_HIT : `TWS_CODE_GC_HIT;
                  end
                end
              end else begin
                n.st = tws_pkg::ST_IDLE;
              end
            end
          end
          if (scl_fall && s.cnt == 4'h8) begin
            n.st = tws_pkg::ST_ACK_OUT;
            n.sda_low = s.ack_drv;
            if (s.st == tws_pkg::ST_RX) begin
              n.act = s.ack_drv ? tws_pkg::ACT_RX : tws_pkg::ACT_NAS;
              if (s.gc) begin
                n.pcode = s.ack_drv ? `TWS_CODE_GC_ACK : `TWS_CODE_GC_NACK;
              end else begin
                n.pcode = s.ack_drv ? `TWS_CODE_RX_ACK : `TWS_CODE_RX_NACK;
              end
            end
          end
        end
        tws_pkg::ST_TX: begin
          if (scl_rise) begin
            n.cnt = s.cnt + 4'h1;
            n.sh = {s.sh[6:0], 1'b1};
          end
          if (scl_fall) begin
            if (s.cnt == 4'h8) begin
              n.sda_low = 1'b0;
              n.st = tws_pkg::ST_ACK_IN;
            end else begin
              n.sda_low = ~s.sh[7];
            end
          end
        end
        tws_pkg::ST_ACK_OUT, tws_pkg::ST_ACK_IN: begin
          if (scl_rise && s.st == tws_pkg::ST_ACK_IN) begin
            // the master's answer picks the next code
            if (!s.sda_s) begin
              n.pcode = s.last ? `TWS_CODE_TX_LAST_ACK : `TWS_CODE_TX_ACK;
              n.act = s.last ? tws_pkg::ACT_NAS : tws_pkg::ACT_TX;
            end else begin
              n.pcode = `TWS_CODE_TX_NACK;
              n.act = tws_pkg::ACT_NAS;
            end
          end
          if (scl_fall) begin
            n.sda_low = 1'b0;
            n.flag = 1'b1;
            n.code = s.pcode;
            n.st = tws_pkg::ST_WAIT;
            n.wake = s.sleep;
            if (s.st == tws_pkg::ST_ACK_OUT && !s.sleep) begin
              n.dr = s.sh;
            end
          end
        end
        tws_pkg::ST_WAIT: begin
          // no move here: the flag clear above has already chosen the next state
        end
        tws_pkg::ST_GEN_START: begin
          // SDA stays low after the hold; releasing it with SCL high would look like STOP
          n.tmr = s.tmr + 7'h01;
          if (s.tmr == 7'(`TWS_START_HOLD_CYC - 1)) begin
            n.st = tws_pkg::ST_WAIT;
            n.flag = 1'b1;
            n.code = `TWS_CODE_START;
            n.act = tws_pkg::ACT_NONE;
          end
        end
      endcase
    end
    n.scl_low = n.st == tws_pkg::ST_WAIT;
  end

  // single state register; lines idle high out of reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.code <= `TWS_CODE_IDLE;
      s.oar <= `TWS_OAR_RST;
      s.scl_m <= 1'b1;
      s.scl_s <= 1'b1;
      s.scl_p <= 1'b1;
      s.sda_m <= 1'b1;
      s.sda_s <= 1'b1;
      s.sda_p <= 1'b1;
    end else begin
      s <= n;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_addr_done;
    s.en && s.st == tws_pkg::ST_ADDR && scl_rise && s.cnt == 4'h7;
  endsequence
  sequence s_ack_in_fall;
    s.en && s.st == tws_pkg::ST_ACK_IN && scl_fall && !start_det && !stop_det;
  endsequence
  sequence s_clear_in_wait;
    s.en && s.st == tws_pkg::ST_WAIT && clr_wr && !start_det && !stop_det;
  endsequence

  property p_ea_gate;
    s_addr_done ##0 !s.ea |=> s.st == tws_pkg::ST_IDLE && !s.adr;
  endproperty
  a_ea_gate: assert property (p_ea_gate) else $error("address taken with ack_enable clear");
  property p_gc_gate;
    s_addr_done ##0 (abyte == 8'h00 && !s.oar[0] && s.oar[7:1] != 7'h00) |=> s.st == tws_pkg::ST_IDLE;
  endproperty
  a_gc_gate: assert property (p_gc_gate) else $error("general call taken while disabled");
  property p_own_dir;
    s_addr_done ##0 (s.ea && abyte[7:1] == s.oar[7:1])
      |=> s.adr && s.act == ($past(abyte[0]) ? tws_pkg::ACT_TX : tws_pkg::ACT_RX);
  endproperty
  a_own_dir: assert property (p_own_dir) else $error("direction bit picked wrong mode");
  property p_start_gen;
    s.en && s.st == tws_pkg::ST_IDLE && s.spend && !s.busy && !start_det && !stop_det
      |=> s.st == tws_pkg::ST_GEN_START ##1 line.sda_oe;
  endproperty
  a_start_gen: assert property (p_start_gen) else $error("pending start not generated");
  property p_rx_ack;
    s_clear_in_wait ##0 s.act == tws_pkg::ACT_RX
      |=> s.st == tws_pkg::ST_RX && s.ack_drv == $past(pwdata[`TWS_CTRL_EA]) && !line.scl_oe;
  endproperty
  a_rx_ack: assert property (p_rx_ack) else $error("ack choice not taken from written bit");
  property p_nas;
    s_clear_in_wait ##0 s.act == tws_pkg::ACT_NAS
      |=> s.st == tws_pkg::ST_IDLE && !s.adr && s.spend == $past(pwdata[`TWS_CTRL_STA]);
  endproperty
  a_nas: assert property (p_nas) else $error("not left addressed state");
  property p_stop_code;
    s.en && s.adr && stop_det && s.st != tws_pkg::ST_GEN_START |=> s.flag && s.code == 8'hA0;
  endproperty
  a_stop_code: assert property (p_stop_code) else $error("stop while addressed not posted");
  property p_status_mask;
    psel && !penable && reg_sel(paddr) == tws_pkg::REG_STAT
      |=> prdata[7:2] == {$past(s.code[7:3]), 1'b0};
  endproperty
  a_status_mask: assert property (p_status_mask) else $error("status read mismatch");
  property p_final;
    s_ack_in_fall ##0 s.last
      |=> s.flag && s.act == tws_pkg::ACT_NAS && (s.code == 8'hC0 || s.code == 8'hC8);
  endproperty
  a_final: assert property (p_final) else $error("final byte code wrong");
  property p_hold;
    s.en && s.st == tws_pkg::ST_WAIT && !clr_wr && !start_det && !stop_det |=> line.scl_oe;
  endproperty
  a_hold: assert property (p_hold) else $error("SCL released before flag clear");
  property p_rx_code;
    s.en && s.st == tws_pkg::ST_ACK_OUT && scl_fall && !s.sleep && s.pcode == 8'h80
      |=> s.flag && s.code == 8'h80 && s.dr == $past(s.sh);
  endproperty
  a_rx_code: assert property (p_rx_code) else $error("received byte not posted");

endmodule : tws_engine

// ---- verification/tws_bus_master.sv ----
module tws_bus_master (
  input wire logic pclk,
  input wire logic scl_line,
  input wire logic sda_line,
  output logic scl_rel,
  output logic sda_rel
);
  timeunit 1ns;
  timeprecision 1ps;

  // both lines released at power-up; pull-ups make them idle high
  initial begin
    scl_rel = 1'b1;
    sda_rel = 1'b1;
  end

  // release scl and wait out any stretching by the slave, bounded so a stuck line cannot hang us
  task automatic scl_up;
    int k;
    scl_rel <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (scl_line !== 1'b1 && k < 4000);
    repeat (3) @(posedge pclk); // four cycles high, four low: 400 ns per bit
  endtask : scl_up

  // one bit: data set while scl low, sampled late in the high phase
  task automatic bit_io(input logic b, output logic s);
    sda_rel <= b;
    repeat (4) @(posedge pclk);
    scl_up();
    s = sda_line;
    scl_rel <= 1'b0;
  endtask : bit_io

  task automatic bus_start;
    sda_rel <= 1'b1;
    repeat (2) @(posedge pclk);
    scl_up();
    sda_rel <= 1'b0;
    repeat (4) @(posedge pclk);
    scl_rel <= 1'b0;
  endtask : bus_start

  task automatic bus_stop;
    sda_rel <= 1'b0;
    repeat (4) @(posedge pclk);
    scl_up();
    sda_rel <= 1'b1;
    repeat (8) @(posedge pclk);
  endtask : bus_stop

  // msb first, ninth bit is the slave's answer
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], s);
    bit_io(1'b1, ack);
  endtask : send_byte

  // ack asks for another byte, nack ends the read
  task automatic recv_byte(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, d[i]);
    bit_io(nack, s);
  endtask : recv_byte
endmodule : tws_bus_master

// ---- verification/two_wire_slave_engine_bench.sv ----
`include "tws_params.svh"

module two_wire_slave_engine_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [11:0] a;
    logic w;
    logic [7:0] d;
    logic [7:0] e;
    logic err;
  } tws_row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic arb_lost = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, wake_req, m_scl, m_sda, scl_in, sda_in, ack, e;
  logic [7:0] r;
  tws_pkg::tws_drive_t line;
  int num_errors = 0;
  int checked = 0;
  tws_row_t rows [12] = '{
    '{`TWS_OFS_STAT, 1'b0, 8'h00, 8'hF8, 1'b0}, '{`TWS_OFS_OAR, 1'b0, 8'h00, 8'h00, 1'b0},
    '{`TWS_OFS_CTRL, 1'b0, 8'h00, 8'h00, 1'b0}, '{`TWS_OFS_OAR, 1'b1, 8'h55, 8'h00, 1'b0},
    '{`TWS_OFS_OAR, 1'b0, 8'h00, 8'h55, 1'b0}, '{`TWS_OFS_STAT, 1'b1, 8'h02, 8'h00, 1'b0},
    '{`TWS_OFS_STAT, 1'b0, 8'h00, 8'hFA, 1'b0}, '{`TWS_OFS_STAT, 1'b1, 8'h00, 8'h00, 1'b0},
    '{12'h020, 1'b0, 8'h00, 8'h00, 1'b1},
    '{`TWS_OFS_DATA, 1'b1, 8'h77, 8'h00, 1'b0}, '{`TWS_OFS_CTRL, 1'b0, 8'h00, 8'h08, 1'b0}, // refused data write
    '{`TWS_OFS_DATA, 1'b0, 8'h00, 8'h00, 1'b0}};

  always #25 pclk = ~pclk;

  // wired-and with pull-ups: anyone pulling low wins
  assign scl_in = m_scl & ~line.scl_oe;
  assign sda_in = m_sda & ~line.sda_oe;

  tws_engine tws_engine_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl_in),
    .sda_in(sda_in), .arb_lost(arb_lost), .line(line), .wake_req(wake_req));
  tws_bus_master tws_bus_master_i (.pclk(pclk), .scl_line(scl_in), .sda_line(sda_in), .scl_rel(m_scl),
    .sda_rel(m_sda));

  task automatic final_report;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report

  task automatic chk8(input string n, input logic [7:0] x, input logic [7:0] g);
    checked++;
    if (g !== x) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, x, g);
    end
  endtask : chk8

  task automatic chk1(input string n, input logic x, input logic g);
    checked++;
    if (g !== x) begin
      num_errors++;
      $display("MISMATCH %s expected %b seen %b", n, x, g);
    end
  endtask : chk1

  // request held from setup until pready is sampled high; data taken at that edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    r = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // poll the flag with a bound, then read the posted code
  task automatic expect_code(input logic [7:0] c);
    int k;
    k = 0;
    r = 8'h00;
    while (r[7] !== 1'b1 && k < 400) begin
      apb(1'b0, `TWS_OFS_CTRL, 8'h00);
      k++;
    end
    apb(1'b0, `TWS_OFS_STAT, 8'h00);
    chk8("status", c, r);
  endtask : expect_code

  initial begin
    repeat (40000) @(posedge pclk);
    num_errors++;
    final_report();
  end

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    // register table: reset values, read-back, prescaler bits, unmapped place
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w)
        chk8("register", rows[i].e, r);
      chk1("slverr", rows[i].err, e);
    end
    apb(1'b1, `TWS_OFS_CTRL, 8'h44);
    // write to own address: data acked, then nacked with ack_enable clear
    tws_bus_master_i.bus_start();
    tws_bus_master_i.send_byte(8'h54, ack);
    chk1("addr ack", 1'b0, ack);
    expect_code(8'h60);
    chk1("scl stretch", 1'b1, line.scl_oe);
    apb(1'b1, `TWS_OFS_CTRL, 8'hC4);
    tws_bus_master_i.send_byte(8'h3C, ack);
    chk1("data ack", 1'b0, ack);
    expect_code(8'h80);
    apb(1'b0, `TWS_OFS_DATA, 8'h00);
    chk8("rx data", 8'h3C, r);
    apb(1'b1, `TWS_OFS_CTRL, 8'h84);
    tws_bus_master_i.send_byte(8'hC3, ack);
    chk1("data nack", 1'b1, ack);
    expect_code(8'h88);
    apb(1'b1, `TWS_OFS_CTRL, 8'hC4);
    tws_bus_master_i.bus_stop();
    apb(1'b0, `TWS_OFS_STAT, 8'h00);
    chk8("no stop code", 8'hF8, r);
    // general call, then isolation with ack_enable clear
    tws_bus_master_i.bus_start();
    tws_bus_master_i.send_byte(8'h00, ack);
    chk1("gc ack", 1'b0, ack);
    expect_code(8'h70);
    apb(1'b1, `TWS_OFS_CTRL, 8'hC4);
    tws_bus_master_i.send_byte(8'h11, ack);
    expect_code(8'h90);
    apb(1'b1, `TWS_OFS_CTRL, 8'h84);
    tws_bus_master_i.send_byte(8'h22, ack);
    chk1("gc nack", 1'b1, ack);
    expect_code(8'h98);
    apb(1'b1, `TWS_OFS_CTRL, 8'h84);
    tws_bus_master_i.bus_stop();
    tws_bus_master_i.bus_start();
    tws_bus_master_i.send_byte(8'h54, ack);
    chk1("isolated", 1'b1, ack);
    tws_bus_master_i.bus_stop();
    apb(1'b1, `TWS_OFS_CTRL, 8'h44);
    // read: normal byte, last byte answered with ack, then all ones
    tws_bus_master_i.bus_start();
    tws_bus_master_i.send_byte(8'h55, ack);
    chk1("read ack", 1'b0, ack);
    expect_code(8'hA8);
    apb(1'b1, `TWS_OFS_DATA, 8'h96);
    apb(1'b1, `TWS_OFS_CTRL, 8'hC4);
    tws_bus_master_i.recv_byte(1'b0, r);
    chk8("tx byte", 8'h96, r);
    expect_code(8'hB8);
    apb(1'b1, `TWS_OFS_DATA, 8'h5A);
    apb(1'b1, `TWS_OFS_CTRL, 8'h84);
    tws_bus_master_i.recv_byte(1'b0, r);
    chk8("last byte", 8'h5A, r);
    expect_code(8'hC8);
    apb(1'b1, `TWS_OFS_CTRL, 8'hC4);
    tws_bus_master_i.recv_byte(1'b1, r);
    chk8("released", 8'hFF, r);
    tws_bus_master_i.bus_stop();
    // read after lost arbitration, last byte answered with nack
    @(posedge pclk);
    arb_lost <= 1'b1;
    @(posedge pclk);
    arb_lost <= 1'b0;
    tws_bus_master_i.bus_start();
    tws_bus_master_i.send_byte(8'h55, ack);
    expect_code(8'hB0);
    apb(1'b1, `TWS_OFS_DATA, 8'hA5);
    apb(1'b1, `TWS_OFS_CTRL, 8'h84);
    tws_bus_master_i.recv_byte(1'b1, r);
    chk8("arb byte", 8'hA5, r);
    expect_code(8'hC0);
    apb(1'b1, `TWS_OFS_CTRL, 8'hC4);
    tws_bus_master_i.bus_stop();
    // general call switched off
    apb(1'b1, `TWS_OFS_OAR, 8'h54);
    tws_bus_master_i.bus_start();
    tws_bus_master_i.send_byte(8'h00, ack);
    chk1("gc off", 1'b1, ack);
    tws_bus_master_i.bus_stop();
    // sleep match holds scl, then stop while addressed, then start request
    apb(1'b1, `TWS_OFS_PWR, 8'h01);
    tws_bus_master_i.bus_start();
    tws_bus_master_i.send_byte(8'h54, ack);
    expect_code(8'h60);
    chk1("wake", 1'b1, wake_req);
    chk1("wake scl", 1'b1, line.scl_oe);
    apb(1'b1, `TWS_OFS_CTRL, 8'hC4);
    apb(1'b1, `TWS_OFS_PWR, 8'h00);
    chk1("wake end", 1'b0, wake_req);
    tws_bus_master_i.bus_stop();
    expect_code(8'hA0);
    apb(1'b1, `TWS_OFS_CTRL, 8'hE4);
    expect_code(8'h08);
    chk1("start sda", 1'b1, line.sda_oe);
    apb(1'b1, `TWS_OFS_CTRL, 8'hC4);
    // reset in mid-run clears lines and registers
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk1("reset scl", 1'b0, line.scl_oe);
    chk1("reset sda", 1'b0, line.sda_oe);
    presetn <= 1'b1;
    apb(1'b0, `TWS_OFS_CTRL, 8'h00);
    chk8("reset ctrl", 8'h00, r);
    apb(1'b0, `TWS_OFS_STAT, 8'h00);
    chk8("reset status", 8'hF8, r);
    final_report();
  end
endmodule : two_wire_slave_engine_bench
